// ==== prs_pkg.sv ====
package prs_pkg;

	// Clock and time base
	localparam int CLK_MHZ = 125;
	localparam int PUD_TIME_US = 72000;
	// Nominal internal RC oscillator rate used to time the power-up delay
	localparam int RC_OSC_KHZ = 100;
	localparam int PUD_RC_TICKS = PUD_TIME_US * RC_OSC_KHZ / 1000;
	localparam int LSR_QUAL_NS = 100000;
	localparam int LSR_QUAL_CYCLES = (LSR_QUAL_NS * CLK_MHZ + 999) / 1000;
	localparam int OSC_START_CYCLES = 1024;
	localparam int CNT_W = 24;

	// Register bus
	localparam int ADR_W = 8;
	localparam logic [ADR_W-1:0] ADDR_PWR_STAT = 8'h00;
	localparam logic [ADR_W-1:0] ADDR_CFG = 8'h04;
	localparam logic [ADR_W-1:0] ADDR_STAT = 8'h08;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;

	// Field positions
	localparam int PSTAT_LOW_BIT = 0;
	localparam int PSTAT_POR_BIT = 1;
	localparam int CFG_OSC_LSB = 0;
	localparam int CFG_PUD_OFF_BIT = 2;
	localparam int CFG_LSR_EN_BIT = 3;
	localparam logic [3:0] CFG_RESET = 4'h7;
	localparam logic [1:0] PSTAT_RESET = 2'h0;

	// Program counter restart values
	localparam int PC_W = 13;
	localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
	localparam logic [PC_W-1:0] PC_IRQ_VECTOR = 13'h0004;
	localparam logic [PC_W-1:0] PC_STEP = 13'h0001;

	// Synchroniser lanes
	localparam int SY_RISE = 0;
	localparam int SY_LOW = 1;
	localparam int SY_MCLEAR = 2;
	localparam int SY_RC = 3;
	localparam int SY_OSC = 4;

	typedef enum logic [1:0] {
		OSC_LOW_POWER = 2'b00,
		OSC_STANDARD = 2'b01,
		OSC_HIGH_SPEED = 2'b10,
		OSC_RC = 2'b11
	} prs_osc_t;

	typedef enum logic [2:0] {
		ST_PUD = 3'b000,
		ST_OSC_START = 3'b001,
		ST_RUN = 3'b011,
		ST_WAKE = 3'b010,
		ST_LOW_HOLD = 3'b110
	} prs_state_t;

	function automatic logic is_crystal(input logic [1:0] osc);
		is_crystal = (osc != OSC_RC);
	endfunction

endpackage

// ==== prs_top.sv ====
`timescale 1ns/1ps

// Behaviour
// - A supply-rise pulse starts a power-on reset sequence.
// - Power-up delay is nominally 72 ms, started by power-on reset or by recovery from low-supply reset.
// - Core held in reset while delay counts; delay timed by internal RC oscillator.
// - Power-up delay applied when its config bit is 0, skipped when 1 unless low-supply reset is enabled.
// - After power-up delay, or at once, count 1024 oscillator input cycles.
// - Start-up count only in crystal modes, only on power-on, low-supply reset or wake-up.
// - With low-supply reset enabled, a qualified low supply resets the device.
// - After low supply, hold until recovered, then run full power-up delay.
// - Low supply during power-up delay restarts the whole low-supply sequence.
// - Low-supply reset enabled forces the power-up delay on.
// - Power-up runs delay then start-up count; leave reset after the last.
// - Master-clear held past all delays releases execution at once.
// - Status bit 0 cleared on low-supply reset; software sets and checks it.
// - Status bit 0 holds no valid information while low-supply reset is off.
// - Status bit 1 cleared on power-on reset only; software sets it.
// - Time-out and power-down flags encode each reset cause.
// - Resets load PC zero; wakes continue at next address or interrupt vector.
// - Status register bank bits cleared and flags set per reset cause.
// - Two-bit oscillator select: 11 RC, 10/01/00 crystal modes.
module prs_top #(
	parameter int PUD_TICKS = prs_pkg::PUD_RC_TICKS,
	parameter int LSR_QUAL = prs_pkg::LSR_QUAL_CYCLES
) (
	// Clock and reset
	input wire logic REF_CLK_I,
	input wire logic RSTN_I,
	// Wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [prs_pkg::ADR_W-1:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// Supply monitors and pins
	input wire logic SUPPLY_RISE_I,
	input wire logic LOW_SUPPLY_I,
	input wire logic MASTER_CLEAR_N_I,
	input wire logic RC_OSC_I,
	input wire logic OSC_INPUT_PIN_I,
	// Core events
	input wire logic SLEEP_I,
	input wire logic WDT_RESET_I,
	input wire logic WDT_WAKE_I,
	input wire logic IRQ_WAKE_I,
	input wire logic GLOBAL_IRQ_ENABLE_I,
	input wire logic [prs_pkg::PC_W-1:0] PC_NEXT_I,
	// Core control
	output logic CORE_RESET_O,
	output logic WAKE_HOLD_O,
	output logic TIMEOUT_FLAG_O,
	output logic POWERDOWN_FLAG_O,
	output logic STATUS_BANK_CLR_O,
	output logic PC_LOAD_O,
	output logic [prs_pkg::PC_W-1:0] PC_VALUE_O
);
	import prs_pkg::*;

	localparam logic [CNT_W-1:0] PUD_LAST = CNT_W'(PUD_TICKS - 1);
	localparam logic [CNT_W-1:0] LSR_LAST = CNT_W'(LSR_QUAL - 1);
	localparam logic [CNT_W-1:0] OSC_LAST = CNT_W'(OSC_START_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_ONE = 24'h00_0001;
	localparam logic [CNT_W-1:0] CNT_ZERO = 24'h00_0000;

	logic [4:0] sync1_q;
	logic [4:0] sync2_q;
	logic [4:0] sync3_q;

	// Pins are asynchronous; the third stage only feeds edge detection
	always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			sync1_q <= 5'h04;
			sync2_q <= 5'h04;
			sync3_q <= 5'h04;
		end else begin
			sync1_q <= {OSC_INPUT_PIN_I, RC_OSC_I, MASTER_CLEAR_N_I, LOW_SUPPLY_I,
				SUPPLY_RISE_I};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	logic rise_evt;
	logic low_s;
	logic mclear_n_s;
	logic mclear_fall;
	logic rc_edge;
	logic osc_edge;

	assign rise_evt = sync2_q[SY_RISE] & ~sync3_q[SY_RISE];
	assign low_s = sync2_q[SY_LOW];
	assign mclear_n_s = sync2_q[SY_MCLEAR];
	assign mclear_fall = sync3_q[SY_MCLEAR] & ~sync2_q[SY_MCLEAR];
	assign rc_edge = sync2_q[SY_RC] & ~sync3_q[SY_RC];
	assign osc_edge = sync2_q[SY_OSC] & ~sync3_q[SY_OSC];

	// Register bus and software state
	logic ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	logic [1:0] pstat_q, pstat_d;
	logic [3:0] cfg_q, cfg_d;

	// Sequencer state
	prs_state_t state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [CNT_W-1:0] low_cnt_q, low_cnt_d;
	logic to_q, to_d;
	logic pd_q, pd_d;
	logic irq_wake_q, irq_wake_d;
	logic core_rst_q, core_rst_d;
	logic wake_hold_q, wake_hold_d;
	logic bank_clr_q, bank_clr_d;
	logic pc_load_q, pc_load_d;
	logic [PC_W-1:0] pc_q, pc_d;

	logic [1:0] osc_sel;
	logic pud_en;
	logic lsr_en;
	logic crystal;
	logic low_hit;
	logic por_clr;
	logic low_clr;
	logic wdt_rst;

	assign osc_sel = cfg_q[CFG_OSC_LSB +: 2];
	assign lsr_en = cfg_q[CFG_LSR_EN_BIT];
	assign pud_en = ~cfg_q[CFG_PUD_OFF_BIT] | lsr_en;
	assign crystal = is_crystal(osc_sel);

	function automatic logic hit(input logic [ADR_W-1:0] a, input logic [ADR_W-1:0] r);
		hit = (a[ADR_W-1:2] == r[ADR_W-1:2]);
	endfunction

	always_comb begin
		ack_d = WB_CYC_I & WB_STB_I & ~ack_q;
		rdat_d = RD_ZERO;
		pstat_d = pstat_q;
		cfg_d = cfg_q;
		if (WB_CYC_I && WB_STB_I && !ack_q) begin
			if (hit(WB_ADR_I, ADDR_PWR_STAT)) begin
				rdat_d = {30'h0000_0000, pstat_q};
			end else if (hit(WB_ADR_I, ADDR_CFG)) begin
				rdat_d = {28'h000_0000, cfg_q};
			end else if (hit(WB_ADR_I, ADDR_STAT)) begin
				rdat_d = {25'h000_0000, wake_hold_q, core_rst_q, pd_q, to_q, state_q};
			end
		end
		// Write lands on the edge where the master sees ack
		if (WB_CYC_I && WB_STB_I && WB_WE_I && ack_q && WB_SEL_I[0]) begin
			if (hit(WB_ADR_I, ADDR_PWR_STAT)) begin
				pstat_d = WB_DAT_I[1:0];
			end else if (hit(WB_ADR_I, ADDR_CFG)) begin
				cfg_d = WB_DAT_I[3:0];
			end
		end
		// Hardware clear beats a simultaneous software write
		if (por_clr) begin
			pstat_d[PSTAT_POR_BIT] = 1'b0;
		end
		if (low_clr) begin
			pstat_d[PSTAT_LOW_BIT] = 1'b0;
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			ack_q <= 1'b0;
			rdat_q <= RD_ZERO;
			pstat_q <= PSTAT_RESET;
			cfg_q <= CFG_RESET;
		end else begin
			ack_q <= ack_d;
			rdat_q <= rdat_d;
			pstat_q <= pstat_d;
			cfg_q <= cfg_d;
		end
	end

	assign WB_ACK_O = ack_q;
	assign WB_DAT_O = rdat_q;

	// Qualified low supply; short dips reset the count and cause nothing
	assign low_hit = lsr_en & low_s & (low_cnt_q == LSR_LAST);

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		low_cnt_d = CNT_ZERO;
		to_d = to_q;
		pd_d = pd_q;
		irq_wake_d = irq_wake_q;
		bank_clr_d = 1'b0;
		pc_load_d = 1'b0;
		pc_d = pc_q;
		por_clr = 1'b0;
		low_clr = 1'b0;
		wdt_rst = 1'b0;
		if (lsr_en && low_s && low_cnt_q != LSR_LAST) begin
			low_cnt_d = low_cnt_q + CNT_ONE;
		end else if (lsr_en && low_s) begin
			low_cnt_d = low_cnt_q;
		end
		if (rise_evt) begin
			// Power-on: power-up delay, then start-up count
			por_clr = 1'b1;
			to_d = 1'b1;
			pd_d = 1'b1;
			bank_clr_d = 1'b1;
			pc_load_d = 1'b1;
			pc_d = PC_RESET;
			cnt_d = CNT_ZERO;
			if (pud_en) begin
				state_d = ST_PUD;
			end else if (crystal) begin
				state_d = ST_OSC_START;
			end else begin
				state_d = ST_RUN;
			end
		end else if (low_hit && state_q != ST_LOW_HOLD) begin
			// Also taken during the power-up delay, which restarts it
			low_clr = 1'b1;
			to_d = 1'b1;
			pd_d = 1'b1;
			bank_clr_d = 1'b1;
			pc_load_d = 1'b1;
			pc_d = PC_RESET;
			state_d = ST_LOW_HOLD;
		end else begin
			case (state_q)
				ST_LOW_HOLD: begin
					cnt_d = CNT_ZERO;
					if (!low_s || !lsr_en) begin
						state_d = ST_PUD;
					end
				end
				ST_PUD: begin
					if (!pud_en) begin
						cnt_d = CNT_ZERO;
						state_d = crystal ? ST_OSC_START : ST_RUN;
					end else if (rc_edge) begin
						if (cnt_q == PUD_LAST) begin
							cnt_d = CNT_ZERO;
							state_d = crystal ? ST_OSC_START : ST_RUN;
						end else begin
							cnt_d = cnt_q + CNT_ONE;
						end
					end
				end
				ST_OSC_START: begin
					if (!crystal) begin
						state_d = ST_RUN;
					end else if (osc_edge) begin
						if (cnt_q == OSC_LAST) begin
							state_d = ST_RUN;
						end else begin
							cnt_d = cnt_q + CNT_ONE;
						end
					end
				end
				ST_RUN: begin
					cnt_d = CNT_ZERO;
					if (WDT_RESET_I && !SLEEP_I) begin
						wdt_rst = 1'b1;
						to_d = 1'b0;
						pd_d = 1'b1;
						bank_clr_d = 1'b1;
						pc_load_d = 1'b1;
						pc_d = PC_RESET;
					end else if (mclear_fall) begin
						// Awake master-clear leaves both flags as they were
						if (SLEEP_I) begin
							to_d = 1'b1;
							pd_d = 1'b0;
						end
						bank_clr_d = 1'b1;
						pc_load_d = 1'b1;
						pc_d = PC_RESET;
					end else if (SLEEP_I && WDT_WAKE_I) begin
						to_d = 1'b0;
						pd_d = 1'b0;
						irq_wake_d = 1'b0;
						state_d = ST_WAKE;
					end else if (SLEEP_I && IRQ_WAKE_I) begin
						to_d = 1'b1;
						pd_d = 1'b0;
						irq_wake_d = 1'b1;
						state_d = ST_WAKE;
					end
				end
				ST_WAKE: begin
					if (!crystal || (osc_edge && cnt_q == OSC_LAST)) begin
						state_d = ST_RUN;
						cnt_d = CNT_ZERO;
						pc_load_d = 1'b1;
						if (irq_wake_q && GLOBAL_IRQ_ENABLE_I) begin
							pc_d = PC_IRQ_VECTOR;
						end else begin
							pc_d = PC_NEXT_I + PC_STEP;
						end
					end else if (osc_edge) begin
						cnt_d = cnt_q + CNT_ONE;
					end
				end
				default: begin
					state_d = ST_PUD;
					cnt_d = CNT_ZERO;
				end
			endcase
		end
		// Master-clear only gates the core; the timers above ignore it
		core_rst_d = (state_d != ST_RUN && state_d != ST_WAKE) | ~mclear_n_s;
		// Power-on always pulses the core reset, even with every delay skipped
		core_rst_d = core_rst_d | wdt_rst | rise_evt;
		wake_hold_d = (state_d == ST_WAKE);
	end

	always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			state_q <= ST_PUD;
			cnt_q <= CNT_ZERO;
			low_cnt_q <= CNT_ZERO;
			to_q <= 1'b1;
			pd_q <= 1'b1;
			irq_wake_q <= 1'b0;
			core_rst_q <= 1'b1;
			wake_hold_q <= 1'b0;
			bank_clr_q <= 1'b0;
			pc_load_q <= 1'b0;
			pc_q <= PC_RESET;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			low_cnt_q <= low_cnt_d;
			to_q <= to_d;
			pd_q <= pd_d;
			irq_wake_q <= irq_wake_d;
			core_rst_q <= core_rst_d;
			wake_hold_q <= wake_hold_d;
			bank_clr_q <= bank_clr_d;
			pc_load_q <= pc_load_d;
			pc_q <= pc_d;
		end
	end

	assign CORE_RESET_O = core_rst_q;
	assign WAKE_HOLD_O = wake_hold_q;
	assign TIMEOUT_FLAG_O = to_q;
	assign POWERDOWN_FLAG_O = pd_q;
	assign STATUS_BANK_CLR_O = bank_clr_q;
	assign PC_LOAD_O = pc_load_q;
	assign PC_VALUE_O = pc_q;

endmodule // prs_top

// ==== prs_partner.sv ====
`timescale 1ns/1ps
// Far-side oscillators derived from the bus clock, so start-up counts stay exact
module prs_partner (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Oscillators
	output logic rc_o,
	output logic osc_o
);
	logic [1:0] div_q;
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			div_q <= 2'h0;
		end else begin
			div_q <= div_q + 2'h1;
		end
	end
	assign rc_o = div_q[1];
	assign osc_o = div_q[0];
endmodule // prs_partner

// ==== prs_top_assertions.sv ====
`timescale 1ns/1ps
module prs_top_assertions
	import prs_pkg::*;
#(
	parameter int PUD_TICKS = PUD_RC_TICKS,
	parameter int LSR_QUAL = LSR_QUAL_CYCLES
) (
	// Observed ports
	input wire logic REF_CLK_I,
	input wire logic RSTN_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_ACK_O,
	input wire logic SUPPLY_RISE_I,
	input wire logic MASTER_CLEAR_N_I,
	input wire logic SLEEP_I,
	input wire logic WDT_RESET_I,
	input wire logic WDT_WAKE_I,
	input wire logic IRQ_WAKE_I,
	input wire logic [PC_W-1:0] PC_NEXT_I,
	input wire logic CORE_RESET_O,
	input wire logic WAKE_HOLD_O,
	input wire logic TIMEOUT_FLAG_O,
	input wire logic POWERDOWN_FLAG_O,
	input wire logic STATUS_BANK_CLR_O,
	input wire logic PC_LOAD_O,
	input wire logic [PC_W-1:0] PC_VALUE_O
);
	default clocking cb @(posedge REF_CLK_I);
	endclocking
	default disable iff (!RSTN_I);
	a_ack_answer: assert property (
		WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O) else $error("bad ack");
	a_rise_start: assert property (
		$rose(SUPPLY_RISE_I) |-> ##3 (PC_LOAD_O && CORE_RESET_O && STATUS_BANK_CLR_O
		&& PC_VALUE_O == PC_RESET)) else $error("power-on start wrong");
	a_por_flags: assert property (
		$rose(SUPPLY_RISE_I) |-> ##4 (TIMEOUT_FLAG_O && POWERDOWN_FLAG_O))
		else $error("power-on flags wrong");
	a_wdt_flags: assert property (
		WDT_RESET_I && !SLEEP_I && !CORE_RESET_O && !WAKE_HOLD_O |-> ##[1:2]
		(!TIMEOUT_FLAG_O && POWERDOWN_FLAG_O && PC_LOAD_O && PC_VALUE_O == PC_RESET))
		else $error("watchdog reset wrong");
	a_mclear_hold: assert property (
		!MASTER_CLEAR_N_I [*5] |-> CORE_RESET_O) else $error("master clear not held");
	a_wake_hold: assert property (
		SLEEP_I && (WDT_WAKE_I || IRQ_WAKE_I) && !CORE_RESET_O && !WAKE_HOLD_O
		|-> ##[1:2] WAKE_HOLD_O) else $error("wake hold missing");
	a_wake_pc: assert property (
		$fell(WAKE_HOLD_O) && !CORE_RESET_O |-> ##[0:1] (PC_LOAD_O
		&& (PC_VALUE_O == PC_IRQ_VECTOR || PC_VALUE_O == PC_NEXT_I + PC_STEP)))
		else $error("wake restart address wrong");
	a_rst_hold: assert property (
		$rose(SUPPLY_RISE_I) ##4 CORE_RESET_O |-> CORE_RESET_O [*3]) else $error("core not held");
endmodule // prs_top_assertions

bind prs_top prs_top_assertions #(.PUD_TICKS(PUD_TICKS), .LSR_QUAL(LSR_QUAL))
	i_prs_top_assertions (.*);

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
	import prs_pkg::*;
	logic clk, rstn, cyc, stb, we, rise, low, mclear_n, slp, wdr, wdw, irw, global_irq_enable;
	logic ack, rc, osc, core, hold, to_f, pd_f, bclr, pcl;
	logic [7:0] adr;
	logic [31:0] wdat, dat, q;
	logic [12:0] pcn, pcv;
	int n_fail = 0;
	int total_checks = 0;
	int cycles = 0;
	int n;
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	prs_partner i_prs_partner (.clk_i(clk), .rstn_i(rstn), .rc_o(rc), .osc_o(osc));
	// Short counts keep the run small; bounds below are derived from 8 and 4
	prs_top #(.PUD_TICKS(8), .LSR_QUAL(4)) i_prs_top (
		.REF_CLK_I(clk), .RSTN_I(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(dat), .WB_ACK_O(ack),
		.SUPPLY_RISE_I(rise), .LOW_SUPPLY_I(low), .MASTER_CLEAR_N_I(mclear_n), .RC_OSC_I(rc),
		.OSC_INPUT_PIN_I(osc), .SLEEP_I(slp), .WDT_RESET_I(wdr), .WDT_WAKE_I(wdw),
		.IRQ_WAKE_I(irw), .GLOBAL_IRQ_ENABLE_I(global_irq_enable), .PC_NEXT_I(pcn), .CORE_RESET_O(core),
		.WAKE_HOLD_O(hold), .TIMEOUT_FLAG_O(to_f), .POWERDOWN_FLAG_O(pd_f),
		.STATUS_BANK_CLR_O(bclr), .PC_LOAD_O(pcl), .PC_VALUE_O(pcv));
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		q = dat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic hold_len();
		n = 0;
		while (core !== 1'b0 && n < 5000) begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic t_por();
		logic [3:0] cf [5] = '{4'h0, 4'h5, 4'h2, 4'h3, 4'h7};
		int lo [5] = '{2070, 2040, 2070, 28, 1};
		int hi [5] = '{2100, 2065, 2100, 45, 8};
		for (int i = 0; i < 5; i++) begin
			bus(1'b1, ADDR_CFG, {28'h000_0000, cf[i]});
			bus(1'b1, ADDR_PWR_STAT, 32'h0000_0003);
			rise <= 1'b1;
			tick(4);
			hold_len();
			rise <= 1'b0;
			chk("por_len", (n + 4 >= lo[i]) && (n + 4 <= hi[i]), 1'b1);
			bus(1'b0, ADDR_PWR_STAT, 32'h0000_0000);
			chk("pstat_por", q[1], 1'b0);
		end
	endtask
	task automatic t_mclear();
		bus(1'b1, ADDR_CFG, 32'h0000_0003);
		mclear_n <= 1'b0;
		rise <= 1'b1;
		tick(200);
		chk("mclear_por", core, 1'b1);
		mclear_n <= 1'b1;
		rise <= 1'b0;
		hold_len();
		chk("mclear_rel", n <= 5, 1'b1);
		low <= 1'b1;
		tick(20);
		chk("low_off_core", core, 1'b0);
		bus(1'b0, ADDR_PWR_STAT, 32'h0000_0000);
		chk("low_off_stat", q[0], 1'b1);
		low <= 1'b0;
		tick(4);
	endtask
	task automatic t_low();
		bus(1'b1, ADDR_CFG, 32'h0000_000f);
		bus(1'b1, ADDR_PWR_STAT, 32'h0000_0003);
		low <= 1'b1;
		tick(20);
		chk("low_hold", core, 1'b1);
		bus(1'b0, ADDR_PWR_STAT, 32'h0000_0000);
		chk("pstat_low", q[1:0], 2'b10);
		chk("low_flags", {to_f, pd_f}, 2'b11);
		low <= 1'b0;
		tick(16);
		chk("low_delay", core, 1'b1);
		low <= 1'b1;
		tick(10);
		low <= 1'b0;
		hold_len();
		chk("low_restart", (n >= 28) && (n <= 45), 1'b1);
	endtask
	task automatic t_wdt();
		wdr <= 1'b1;
		tick(1);
		wdr <= 1'b0;
		tick(4);
		chk("wdt_flags", {to_f, pd_f}, 2'b01);
		mclear_n <= 1'b0;
		tick(8);
		chk("mclear_core", core, 1'b1);
		chk("mclear_awake", {to_f, pd_f}, 2'b01);
		mclear_n <= 1'b1;
		tick(8);
		slp <= 1'b1;
		mclear_n <= 1'b0;
		tick(8);
		chk("mclear_sleep", {to_f, pd_f}, 2'b10);
		mclear_n <= 1'b1;
		slp <= 1'b0;
		tick(8);
	endtask
	task automatic t_wake(input logic [3:0] cf, input logic irq, input logic g,
		input logic [12:0] pc, input logic [1:0] fl, input int lo, input int hi);
		bus(1'b1, ADDR_CFG, {28'h000_0000, cf});
		global_irq_enable <= g;
		slp <= 1'b1;
		tick(2);
		irw <= irq;
		wdw <= !irq;
		tick(1);
		irw <= 1'b0;
		wdw <= 1'b0;
		n = 1;
		while (pcl !== 1'b1 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		chk("wake_pc", pcv, pc);
		chk("wake_len", (n >= lo) && (n <= hi), 1'b1);
		slp <= 1'b0;
		tick(2);
		chk("wake_flags", {to_f, pd_f}, fl);
	endtask
	initial begin
		{rstn, cyc, stb, we, rise, low, slp, wdr, wdw, irw, global_irq_enable} = '0;
		mclear_n = 1'b1;
		adr = 8'h00;
		wdat = 32'h0000_0000;
		pcn = 13'h0123;
		tick(2);
		chk("rst_core", core, 1'b1);
		chk("rst_flags", {to_f, pd_f}, 2'b11);
		rstn <= 1'b1;
		bus(1'b0, ADDR_CFG, 32'h0000_0000);
		chk("cfg_rst", q, 32'h0000_0007);
		bus(1'b1, 8'h0c, 32'hffff_ffff);
		bus(1'b0, 8'h0c, 32'h0000_0000);
		chk("unmapped", q, 32'h0000_0000);
		t_por();
		t_mclear();
		t_low();
		t_wdt();
		t_wake(4'h1, 1'b0, 1'b0, 13'h0124, 2'b00, 2040, 2070);
		t_wake(4'h3, 1'b1, 1'b0, 13'h0124, 2'b10, 1, 8);
		t_wake(4'h3, 1'b1, 1'b1, PC_IRQ_VECTOR, 2'b10, 1, 8);
		tally_and_finish();
	end
endmodule // tb
